// *** rtl/cseirq_top.sv ***
// Charger and supply event status, masks, auto-acknowledge and open-drain interrupt pin.
// Assumes the serial engine shares this clock and issues one-cycle rd/wr strobes;
// analog conditions and pin levels are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none

module cseirq_top (
   input wire logic clock,
   input wire logic rst_b,
   input wire cseirq_pkg::cseirq_req_t reg_req,
   output logic [7:0] reg_rdata_q,
   input wire logic [7:0] chg_cond_raw,
   input wire cseirq_pkg::cseirq_sup_raw_t sup_raw,
   input wire logic linear_reg_a_enable,
   input wire logic linear_reg_b_enable,
   input wire logic core_lp_flag_enable,
   output logic charger_restart_q,
   output logic int_n_out,
   output logic int_n_oe_q
);
   import cseirq_pkg::*;

   localparam int NSUP = 8;
   // Battery temperature sits in the lowest charger bit
   localparam int CHG_BIT_TEMP = 0;

   logic [7:0] chg_cond;
   logic [NSUP-1:0] sup_sync;
   cseirq_sup_raw_t sup_s;
   cseirq_sup_raw_t sup_raw_cond;
   logic [7:0] sup_cond;
   logic [7:0] chg_stat;
   logic [7:0] chg_ack;
   logic [7:0] sup_stat;
   logic [7:0] sup_ack;
   logic [7:0] chg_mask_q;
   logic [7:0] sup_mask_q;
   logic [7:0] chg_wr_clr;
   logic [7:0] chg_rd_ack;
   logic [7:0] sup_rd_ack;
   logic [7:0] chg_pending;
   logic [7:0] sup_pending;
   logic int_active;

   // Pick the register a request addresses
   function automatic logic hit(input cseirq_req_t r, input logic [7:0] a);
      hit = (r.addr == a);
   endfunction : hit

   // Charger conditions come straight from the analog side
   cseirq_sync #(
      .WIDTH(8)
   ) u_chg_sync (
      .clock(clock),
      .rst_b(rst_b),
      .async_in(chg_cond_raw),
      .sync_out(chg_cond)
   );

   // Lid sense is active low; flip it ahead of the synchroniser so the flops'
   // reset level means no event and the edge cell sees no false edge after reset
   always_comb begin
      sup_raw_cond = sup_raw;
      sup_raw_cond.battery_lid_sense = !sup_raw.battery_lid_sense;
   end

   // Supply conditions and the lid and low-power pins
   cseirq_sync #(
      .WIDTH(NSUP)
   ) u_sup_sync (
      .clock(clock),
      .rst_b(rst_b),
      .async_in(sup_raw_cond),
      .sync_out(sup_sync)
   );

   assign sup_s = cseirq_sup_raw_t'(sup_sync);

   // Supply condition vector; enables come from same-clock register logic
   always_comb begin
      sup_cond = 8'h00;
      sup_cond[SUP_BIT_BUTTON] = sup_s.power_button_request;
      sup_cond[SUP_BIT_LID] = sup_s.battery_lid_sense; // already inverted
      sup_cond[SUP_BIT_UNDERVOLTAGE_LOCKOUT] = sup_s.undervoltage_lockout;
      sup_cond[SUP_BIT_UNUSED] = 1'b0;
      sup_cond[SUP_BIT_LDO_B] = sup_s.linear_regulator_b_fault && linear_reg_b_enable;
      sup_cond[SUP_BIT_LDO_A] = sup_s.linear_regulator_a_fault && linear_reg_a_enable;
      sup_cond[SUP_BIT_MAIN] = sup_s.main_converter_fault;
      sup_cond[SUP_BIT_CORE] = sup_s.core_converter_fault
         || (core_lp_flag_enable && sup_s.low_power_mode);
   end

   // Strobes into the bit cells: write-clear and read-acknowledge
   always_comb begin
      chg_wr_clr = 8'h00;
      chg_rd_ack = 8'h00;
      sup_rd_ack = 8'h00;
      if (reg_req.wr && hit(reg_req, ADDR_CHG_STATUS)) begin
         chg_wr_clr = reg_req.wdata & CHG_WR_CLR_MAP;
      end
      if (reg_req.rd && hit(reg_req, ADDR_CHG_STATUS)) begin
         chg_rd_ack = chg_stat;
      end
      if (reg_req.rd && hit(reg_req, ADDR_SUP_STATUS)) begin
         sup_rd_ack = sup_stat;
      end
   end

   // One status/ack cell per bit, edge or level flavour per map
   for (genvar i = 0; i < 8; i++) begin : g_bits
      cseirq_stat_bit #(
         .EDGE_SET(CHG_EDGE_MAP[i])
      ) u_chg (
         .clock(clock),
         .rst_b(rst_b),
         .cond(chg_cond[i]),
         .wr_clr(chg_wr_clr[i]),
         .rd_ack(chg_rd_ack[i]),
         .stat_q(chg_stat[i]),
         .ack_q(chg_ack[i])
      );
      cseirq_stat_bit #(
         .EDGE_SET(SUP_EDGE_MAP[i])
      ) u_sup (
         .clock(clock),
         .rst_b(rst_b),
         .cond(sup_cond[i]),
         .wr_clr(1'b0),
         .rd_ack(sup_rd_ack[i]),
         .stat_q(sup_stat[i]),
         .ack_q(sup_ack[i])
      );
   end

   // Mask registers; all sources start masked so boot noise stays quiet
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         chg_mask_q <= RST_MASK;
         sup_mask_q <= RST_MASK;
      end else if (reg_req.wr) begin
         if (hit(reg_req, ADDR_CHG_MASK)) begin
            chg_mask_q <= reg_req.wdata;
         end
         if (hit(reg_req, ADDR_SUP_MASK)) begin
            sup_mask_q <= reg_req.wdata;
         end
      end
   end

   // Charger restart pulse on any write-clear of bits 1..4
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         charger_restart_q <= 1'b0;
      end else begin
         charger_restart_q <= |chg_wr_clr;
      end
   end

   // Read data is latched at the strobe, so the only later event missed is an edge that rises in the cycle of a read of its set bit or the one after
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         reg_rdata_q <= RST_STATUS;
      end else if (reg_req.rd) begin
         unique case (reg_req.addr)
            ADDR_CHG_STATUS: reg_rdata_q <= chg_stat;
            ADDR_SUP_STATUS: reg_rdata_q <= sup_stat;
            ADDR_CHG_MASK: reg_rdata_q <= chg_mask_q;
            ADDR_SUP_MASK: reg_rdata_q <= sup_mask_q;
            ADDR_CHG_ACK: reg_rdata_q <= chg_ack;
            ADDR_SUP_ACK: reg_rdata_q <= sup_ack;
            default: reg_rdata_q <= RD_UNMAPPED;
         endcase
      end
   end

   // Pending sources: set, unmasked and not yet acknowledged
   assign chg_pending = chg_stat & ~chg_mask_q & ~chg_ack;
   assign sup_pending = sup_stat & ~sup_mask_q & ~sup_ack;
   assign int_active = |{chg_pending, sup_pending};

   // Open-drain pin: only ever pulls low, registered to avoid glitches
   assign int_n_out = 1'b0;

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         int_n_oe_q <= 1'b0;
      end else begin
         int_n_oe_q <= int_active;
      end
   end

   // Helper history for the checks below
   logic [7:0] sup_cond_q;
   logic [7:0] chg_cond_q;

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         sup_cond_q <= 8'h00;
         chg_cond_q <= 8'h00;
      end else begin
         sup_cond_q <= sup_cond;
         chg_cond_q <= chg_cond;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   // A read of a set charger bit
   sequence s_chg_read_set;
      reg_req.rd && hit(reg_req, ADDR_CHG_STATUS) && (chg_stat != 8'h00);
   endsequence

   // A read of a set supply bit
   sequence s_sup_read_set;
      reg_req.rd && hit(reg_req, ADDR_SUP_STATUS) && (sup_stat != 8'h00);
   endsequence

   property p_mask_reset;
      $rose(rst_b) |-> (chg_mask_q == RST_MASK) && (sup_mask_q == RST_MASK);
   endproperty
   a_mask_reset: assert property (p_mask_reset) else $error("mask not all ones after reset");

   property p_chg_ack_on_read;
      s_chg_read_set |=> ((chg_ack & $past(chg_stat)) == $past(chg_stat));
   endproperty
   a_chg_ack_on_read: assert property (p_chg_ack_on_read) else $error("charger ack not set by read");

   property p_sup_ack_on_read;
      s_sup_read_set |=> ((sup_ack & $past(sup_stat)) == $past(sup_stat));
   endproperty
   a_sup_ack_on_read: assert property (p_sup_ack_on_read) else $error("supply ack not set by read");

   property p_ack_needs_status;
      ((chg_ack & ~chg_stat) != 8'h00) |=> ((chg_ack & ~$past(chg_stat)) == 8'h00);
   endproperty
   a_ack_needs_status: assert property (p_ack_needs_status) else $error("charger ack outlived status");

   property p_sup_ack_clear;
      (sup_stat == 8'h00) |=> (sup_ack == 8'h00);
   endproperty
   a_sup_ack_clear: assert property (p_sup_ack_clear) else $error("supply ack stuck");

   property p_unused_zero;
      sup_stat[SUP_BIT_UNUSED] == 1'b0;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("supply bit 4 set");

   property p_int_follows;
      int_active |=> int_n_oe_q ##0 (int_n_out == 1'b0);
   endproperty
   a_int_follows: assert property (p_int_follows) else $error("interrupt not driven");

   property p_int_release;
      (chg_stat & ~chg_mask_q & ~chg_ack) == 8'h00 && sup_pending == 8'h00 |=> !int_n_oe_q;
   endproperty
   a_int_release: assert property (p_int_release) else $error("interrupt held with nothing pending");

   property p_sup_edge_hold;
      $rose(sup_cond[SUP_BIT_UNDERVOLTAGE_LOCKOUT]) ##1 !sup_cond[SUP_BIT_UNDERVOLTAGE_LOCKOUT] && !sup_ack[SUP_BIT_UNDERVOLTAGE_LOCKOUT]
         |-> ##1 sup_stat[SUP_BIT_UNDERVOLTAGE_LOCKOUT];
   endproperty
   a_sup_edge_hold: assert property (p_sup_edge_hold) else $error("edge supply bit lost");

   property p_chg_level;
      (chg_cond[7] == chg_cond_q[7]) |=> (chg_stat[7] == $past(chg_cond[7]));
   endproperty
   a_chg_level: assert property (p_chg_level) else $error("usb bit not following level");

   property p_restart;
      reg_req.wr && hit(reg_req, ADDR_CHG_STATUS) && ((reg_req.wdata & CHG_WR_CLR_MAP) != 8'h00)
         |=> charger_restart_q && ((chg_stat & $past(reg_req.wdata) & CHG_WR_CLR_MAP) == 8'h00);
   endproperty
   a_restart: assert property (p_restart) else $error("write-clear missed");

   property p_ro_bits;
      reg_req.wr && hit(reg_req, ADDR_CHG_STATUS) && (reg_req.wdata & CHG_WR_CLR_MAP) == 8'h00
         |=> !charger_restart_q;
   endproperty
   a_ro_bits: assert property (p_ro_bits) else $error("read-only write had effect");

   property p_lid_low;
      sup_s.battery_lid_sense [*2] |-> ##1 sup_stat[SUP_BIT_LID] || sup_ack[SUP_BIT_LID]
         || $past(sup_stat[SUP_BIT_LID]);
   endproperty
   a_lid_low: assert property (p_lid_low) else $error("lid bit not set");

   property p_mask_blocks;
      (chg_mask_q == 8'hFF) && (sup_mask_q == 8'hFF) |=> !int_n_oe_q;
   endproperty
   a_mask_blocks: assert property (p_mask_blocks) else $error("masked source reached pin");

   property p_chg_mwr;
      reg_req.wr && hit(reg_req, ADDR_CHG_MASK) |=> chg_mask_q == $past(reg_req.wdata);
   endproperty
   a_chg_mwr: assert property (p_chg_mwr) else $error("charger mask write lost");

   property p_sup_mwr;
      reg_req.wr && hit(reg_req, ADDR_SUP_MASK) |=> sup_mask_q == $past(reg_req.wdata);
   endproperty
   a_sup_mwr: assert property (p_sup_mwr) else $error("supply mask write lost");

   property p_chg_rdd;
      reg_req.rd && hit(reg_req, ADDR_CHG_STATUS) |=> reg_rdata_q == $past(chg_stat);
   endproperty
   a_chg_rdd: assert property (p_chg_rdd) else $error("charger read data wrong");

   property p_sup_rdd;
      reg_req.rd && hit(reg_req, ADDR_SUP_STATUS) |=> reg_rdata_q == $past(sup_stat);
   endproperty
   a_sup_rdd: assert property (p_sup_rdd) else $error("supply read data wrong");

   // A one-cycle temperature pulse must still be set the cycle after it falls
   property p_chg_hold;
      $rose(chg_cond[CHG_BIT_TEMP]) ##1 !chg_cond[CHG_BIT_TEMP] && !chg_ack[CHG_BIT_TEMP]
         |-> ##1 chg_stat[CHG_BIT_TEMP];
   endproperty
   a_chg_hold: assert property (p_chg_hold) else $error("edge charger bit lost");

   property p_chg_clr;
      !chg_cond[CHG_BIT_TEMP] && chg_ack[CHG_BIT_TEMP] |=> !chg_stat[CHG_BIT_TEMP];
   endproperty
   a_chg_clr: assert property (p_chg_clr) else $error("edge charger bit stuck");

   property p_sup_clr;
      !sup_cond[SUP_BIT_UNDERVOLTAGE_LOCKOUT] && sup_ack[SUP_BIT_UNDERVOLTAGE_LOCKOUT] |=> !sup_stat[SUP_BIT_UNDERVOLTAGE_LOCKOUT];
   endproperty
   a_sup_clr: assert property (p_sup_clr) else $error("edge supply bit stuck");

   property p_sup_lvl;
      (sup_stat & ~SUP_EDGE_MAP) == (sup_cond_q & ~SUP_EDGE_MAP);
   endproperty
   a_sup_lvl: assert property (p_sup_lvl) else $error("supply level");

   // Level charger bits trail their condition by one cycle, except after a write-clear
   property p_chg_lvl;
      (chg_stat & ~CHG_EDGE_MAP) == (chg_cond_q & ~CHG_EDGE_MAP & ~$past(chg_wr_clr));
   endproperty
   a_chg_lvl: assert property (p_chg_lvl) else $error("charger level");

   property p_chg_ack_clr;
      (chg_stat == 8'h00) |=> (chg_ack == 8'h00);
   endproperty
   a_chg_ack_clr: assert property (p_chg_ack_clr) else $error("charger ack stuck");

   property p_sup_ack_gone;
      ((sup_ack & ~sup_stat) != 8'h00) |=> ((sup_ack & ~$past(sup_stat)) == 8'h00);
   endproperty
   a_sup_ack_gone: assert property (p_sup_ack_gone) else $error("supply ack outlived");

   property p_rst_cause;
      !(reg_req.wr && hit(reg_req, ADDR_CHG_STATUS)) |=> !charger_restart_q;
   endproperty
   a_rst_cause: assert property (p_rst_cause) else $error("restart without write");

endmodule : cseirq_top

`default_nettype wire

// *** rtl/cseirq_pkg.sv ***
// Constants, register map and carrier types for the charger/supply interrupt block.
// Assumes a serial protocol engine on the same clock presents single-cycle register strobes.

package cseirq_pkg;

   // Register indices on the serial register port
   localparam logic [7:0] ADDR_CHG_STATUS = 8'h01;
   localparam logic [7:0] ADDR_SUP_STATUS = 8'h02;
   localparam logic [7:0] ADDR_CHG_MASK = 8'h03;
   localparam logic [7:0] ADDR_SUP_MASK = 8'h04;
   localparam logic [7:0] ADDR_CHG_ACK = 8'h05;
   localparam logic [7:0] ADDR_SUP_ACK = 8'h06;

   // Reset values and the answer for an unlisted address
   localparam logic [7:0] RST_STATUS = 8'h00;
   localparam logic [7:0] RST_MASK = 8'hFF;
   localparam logic [7:0] RST_ACK = 8'h00;
   localparam logic [7:0] RD_UNMAPPED = 8'hFF;

   // Which status bits are edge-set; the rest follow their condition
   localparam logic [7:0] CHG_EDGE_MAP = 8'h21;
   localparam logic [7:0] SUP_EDGE_MAP = 8'hE0;
   // Charger bits the host may clear by writing a one
   localparam logic [7:0] CHG_WR_CLR_MAP = 8'h1E;

   // Supply field positions
   localparam int SUP_BIT_BUTTON = 7;
   localparam int SUP_BIT_LID = 6;
   localparam int SUP_BIT_UNDERVOLTAGE_LOCKOUT = 5;
   localparam int SUP_BIT_UNUSED = 4;
   localparam int SUP_BIT_LDO_B = 3;
   localparam int SUP_BIT_LDO_A = 2;
   localparam int SUP_BIT_MAIN = 1;
   localparam int SUP_BIT_CORE = 0;

   // One register request from the serial engine
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cseirq_req_t;

   // Raw supply-side conditions from the analog blocks
   typedef struct packed {
      logic power_button_request;
      logic battery_lid_sense;
      logic undervoltage_lockout;
      logic linear_regulator_b_fault;
      logic linear_regulator_a_fault;
      logic main_converter_fault;
      logic core_converter_fault;
      logic low_power_mode;
   } cseirq_sup_raw_t;

endpackage : cseirq_pkg

// *** rtl/cseirq_sync.sv ***
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes the levels are slow compared to the clock; no bus coherency is promised.
`timescale 1ns/1ps
`default_nettype none

module cseirq_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : cseirq_sync

`default_nettype wire

// *** rtl/cseirq_stat_bit.sv ***
// One status bit with its auto-acknowledge bit.
// Assumes cond is already synchronised; rd_ack and wr_clr are single-cycle strobes.
`timescale 1ns/1ps
`default_nettype none

module cseirq_stat_bit #(
   parameter bit EDGE_SET = 1'b0
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic cond,
   input wire logic wr_clr,
   input wire logic rd_ack,
   output logic stat_q,
   output logic ack_q
);
   import cseirq_pkg::*;

   logic prev_q;
   logic stat_d;

   // Edge bits hold until low and acked, so a short pulse is lost only if it starts in the cycle of a read of the set bit or the one after
   always_comb begin
      if (EDGE_SET) begin
         stat_d = (cond && !prev_q) || (stat_q && !(!cond && ack_q));
      end else begin
         stat_d = cond && !wr_clr;
      end
   end

   // Condition history and status
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         prev_q <= 1'b0;
         stat_q <= RST_STATUS[0];
      end else begin
         prev_q <= cond;
         stat_q <= stat_d;
      end
   end

   // Ack sets on a read of a set bit and drops once status clears
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ack_q <= RST_ACK[0];
      end else begin
         ack_q <= stat_q && (ack_q || rd_ack);
      end
   end
endmodule : cseirq_stat_bit

`default_nettype wire

// *** sim/cseirq_host.sv ***
// Host processor model: register strobes and the pulled-up interrupt line.
// Assumes the design's one-cycle rd/wr strobe port on the shared clock.
`timescale 1ns/1ps
`default_nettype none

module cseirq_host (
   input wire logic clock,
   output cseirq_pkg::cseirq_req_t reg_req,
   input wire logic [7:0] reg_rdata_q,
   input wire logic int_n_out,
   input wire logic int_n_oe_q,
   output logic int_line
);
   import cseirq_pkg::*;

   // Idle port at time zero
   initial begin
      reg_req = '0;
   end

   // Pull-up wins whenever the device lets go of the line
   assign int_line = int_n_oe_q ? int_n_out : 1'b1;

   // One write strobe; released fields show inverted values, never the stale ones
   task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clock);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(posedge clock);
      reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
   endtask : reg_write

   // One read strobe; data is registered at the taking edge
   task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
      @(posedge clock);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
      @(posedge clock);
      reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hFF};
      #1;
      data = reg_rdata_q;
   endtask : reg_read

endmodule : cseirq_host

`default_nettype wire

// *** sim/charger_supply_irq_status_test.sv ***
// Self-checking bench for the charger/supply interrupt block.
// Assumes the host model drives the register port; conditions are driven here.
`timescale 1ns/1ps
`default_nettype none

module charger_supply_irq_status_test;
   import cseirq_pkg::*;

   logic clock;
   logic rst_b;
   cseirq_req_t reg_req;
   logic [7:0] reg_rdata_q;
   logic [7:0] chg_cond_raw;
   cseirq_sup_raw_t sup_raw;
   logic [2:0] en;
   logic charger_restart_q;
   logic int_n_out;
   logic int_n_oe_q;
   logic int_line;
   int mismatches;
   int checked;
   int cycles;
   // Supply cases: raw conditions, enables {a, b, low-power flag}, expected status
   localparam logic [7:0] SRAW [9] = '{8'hC0, 8'h00, 8'h60, 8'h58, 8'h58, 8'h44, 8'h42,
                                       8'h41, 8'h41};
   localparam logic [2:0] SEN [9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h6, 3'h0, 3'h0, 3'h1, 3'h0};
   localparam logic [7:0] SEXP [9] = '{8'h80, 8'h40, 8'h20, 8'h00, 8'h0C, 8'h02, 8'h01,
                                       8'h01, 8'h00};
   localparam logic [7:0] RSTV [8] = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF};

   cseirq_top uut (
      .clock(clock),
      .rst_b(rst_b),
      .reg_req(reg_req),
      .reg_rdata_q(reg_rdata_q),
      .chg_cond_raw(chg_cond_raw),
      .sup_raw(sup_raw),
      .linear_reg_a_enable(en[2]),
      .linear_reg_b_enable(en[1]),
      .core_lp_flag_enable(en[0]),
      .charger_restart_q(charger_restart_q),
      .int_n_out(int_n_out),
      .int_n_oe_q(int_n_oe_q)
   );

   cseirq_host host (
      .clock(clock),
      .reg_req(reg_req),
      .reg_rdata_q(reg_rdata_q),
      .int_n_out(int_n_out),
      .int_n_oe_q(int_n_oe_q),
      .int_line(int_line)
   );

   // 25 MHz clock
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // Hang guard; the full sequence needs well under this many cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] v;
      host.reg_read(addr, v);
      check(v, exp);
   endtask : rd_chk

   task automatic pin_chk(input logic exp);
      check({7'h00, int_line}, {7'h00, exp});
   endtask : pin_chk

   // Conditions change on the clock edge; then settle through the synchronisers
   task automatic set_cond(input logic [7:0] chg, input logic [7:0] sup, input logic [2:0] e);
      @(posedge clock);
      chg_cond_raw <= chg;
      sup_raw <= sup;
      en <= e;
      repeat (6) @(posedge clock);
      #1;
   endtask : set_cond

   task automatic wait3();
      repeat (3) @(posedge clock);
      #1;
   endtask : wait3

   initial begin
      rst_b = 1'b0;
      chg_cond_raw = 8'h00;
      sup_raw = 8'h40;
      en = 3'h0;
      mismatches = 0;
      checked = 0;
      cycles = 0;
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      // Reset values, unlisted addresses, writes to read-only places
      for (int a = 0; a < 8; a++) rd_chk(a[7:0], RSTV[a]);
      host.reg_write(8'h02, 8'hFF);
      host.reg_write(8'h05, 8'hFF);
      host.reg_write(8'h06, 8'hFF);
      host.reg_write(8'h01, 8'hE1);
      #1;
      check({7'h00, charger_restart_q}, 8'h00);
      for (int a = 1; a < 7; a++) if (a < 3 || a > 4) rd_chk(a[7:0], 8'h00);
      // Level charger bits, masked then acknowledged
      set_cond(8'hDE, 8'h40, 3'h0);
      pin_chk(1'b1);
      rd_chk(8'h01, 8'hDE);
      rd_chk(8'h05, 8'hDE);
      host.reg_write(8'h03, 8'h00);
      rd_chk(8'h03, 8'h00);
      wait3();
      pin_chk(1'b1);
      set_cond(8'h00, 8'h40, 3'h0);
      rd_chk(8'h01, 8'h00);
      rd_chk(8'h05, 8'h00);
      // Edge bits hold after a pulse until read; a second source pulls the pin low again after the first is acked
      set_cond(8'h21, 8'h40, 3'h0);
      set_cond(8'h00, 8'h40, 3'h0);
      pin_chk(1'b0);
      rd_chk(8'h01, 8'h21);
      wait3();
      pin_chk(1'b1);
      rd_chk(8'h01, 8'h00);
      rd_chk(8'h05, 8'h00);
      set_cond(8'h20, 8'h40, 3'h0);
      rd_chk(8'h01, 8'h20);
      set_cond(8'h22, 8'h40, 3'h0);
      pin_chk(1'b0);
      rd_chk(8'h01, 8'h22);
      wait3();
      pin_chk(1'b1);
      // Write-clear restarts the charger; other bits ignore writes
      set_cond(8'hFF, 8'h40, 3'h0);
      host.reg_write(8'h01, 8'hE1);
      #1;
      check({7'h00, charger_restart_q}, 8'h00);
      host.reg_write(8'h01, 8'h1E);
      #1;
      check({7'h00, charger_restart_q}, 8'h01);
      rd_chk(8'h01, 8'hFF);
      set_cond(8'h00, 8'h40, 3'h0);
      rd_chk(8'h01, 8'h00);
      // Supply mask blocks the pin
      set_cond(8'h00, 8'h60, 3'h0);
      pin_chk(1'b1);
      rd_chk(8'h02, 8'h20);
      set_cond(8'h00, 8'h40, 3'h0);
      rd_chk(8'h02, 8'h00);
      host.reg_write(8'h04, 8'h00);
      rd_chk(8'h04, 8'h00);
      // Every supply source, pin assertion, acknowledge and release
      for (int i = 0; i < 9; i++) begin
         set_cond(8'h00, SRAW[i], SEN[i]);
         pin_chk(SEXP[i] == 8'h00);
         rd_chk(8'h02, SEXP[i]);
         wait3();
         pin_chk(1'b1);
         rd_chk(8'h06, SEXP[i]);
         set_cond(8'h00, 8'h40, 3'h0);
         rd_chk(8'h02, 8'h00);
         rd_chk(8'h06, 8'h00);
      end
      // One-cycle pulses on edge sources are held until read, then released
      @(posedge clock);
      chg_cond_raw <= 8'h01;
      sup_raw <= 8'h60;
      set_cond(8'h00, 8'h40, 3'h0);
      pin_chk(1'b0);
      rd_chk(8'h01, 8'h01);
      rd_chk(8'h02, 8'h20);
      wait3();
      pin_chk(1'b1);
      rd_chk(8'h01, 8'h00);
      rd_chk(8'h02, 8'h00);
      print_verdict();
   end

endmodule : charger_supply_irq_status_test

`default_nettype wire
